// File: inc/jcr_pkg.sv
// Constants shared by the test-port configuration readback block.
package jcr_pkg;
  // Instruction register.
  localparam int IR_WIDTH = 6;
  localparam logic [IR_WIDTH-1:0] INSTR_CFG_IN = 6'h05;
  localparam logic [IR_WIDTH-1:0] INSTR_CFG_OUT = 6'h04;
  localparam logic [IR_WIDTH-1:0] INSTR_BYPASS = 6'h3f;
  localparam logic [IR_WIDTH-1:0] IR_CAPTURE = 6'h01;
  // Configuration words.
  localparam int WORD_BITS = 32;
  localparam int BIT_CNT_W = 5;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 5'h1f;
  localparam logic [31:0] SYNC_WORD = 32'haa995566;
  localparam logic [31:0] NOOP_WORD = 32'h20000000;
  localparam logic [31:0] CMD_RELEASE_LINK = 32'h0000000d;
  localparam logic [31:0] OPTION_RESET = 32'h00000000;
  localparam logic [31:0] READ_RESET = 32'h00000000;
  // Packet header fields.
  localparam int HDR_TYPE_LSB = 29;
  localparam int HDR_OP_LSB = 27;
  localparam int HDR_ADDR_LSB = 13;
  localparam int HDR_ADDR_W = 14;
  localparam int HDR_CNT_W = 11;
  localparam logic [2:0] HDR_TYPE1 = 3'h1;
  localparam logic [1:0] OP_READ = 2'h1;
  localparam logic [1:0] OP_WRITE = 2'h2;
  // Register addresses.
  localparam logic [HDR_ADDR_W-1:0] ADDR_CMD = 14'h0004;
  localparam logic [HDR_ADDR_W-1:0] ADDR_STAT = 14'h0007;
  localparam logic [HDR_ADDR_W-1:0] ADDR_OPTION = 14'h0009;
  // Test access port states.
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR,
    TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
    TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } jcr_tap_t;
endpackage : jcr_pkg

// File: design/jcr_sync.sv
// Two-flop synchroniser for levels and toggles entering a clock domain.
`timescale 1ns/10ps
module jcr_sync #(
  parameter int WIDTH = 1
) (
  // Destination clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Signals.
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : jcr_sync

// File: design/jcr_readback.sv
// Test access port with configuration input and output scan registers and a packet processor.
`timescale 1ns/10ps
// Functional notes
// - Packet words shift MSB first; last bit leaves Shift-DR.
// - Read sequences hold an even word count; processor works on word pairs.
// - Output register presents 32-bit read value, shifted out MSB first.
// - Entering Test-Logic-Reset releases the configuration link.
// - Readable registers answer reads; others return zero.
// - Test-port packets are processed exactly like parallel-port packets.
// - Scan registers forward words to the processor and return read data.
module jcr_readback
  import jcr_pkg::*;
(
  // System clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Test access port.
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdoOe_n,
  // Parallel configuration port.
  input wire logic [31:0] parWord,
  input wire logic parValid,
  output logic parReady,
  // Device state.
  input wire logic [31:0] statusWord,
  output logic [31:0] optionWord,
  output logic linkActive
);
  // Test-clock domain.
  jcr_tap_t tapState;
  jcr_tap_t next_tapState;
  logic [IR_WIDTH-1:0] irShift;
  logic [IR_WIDTH-1:0] instr;
  logic bypassBit;
  logic [31:0] inShift;
  logic [BIT_CNT_W-1:0] inCount;
  logic [31:0] inWord;
  logic inToggle;
  logic [31:0] outShift;
  logic [31:0] outHold;
  logic readToggleTck;
  logic readTogglePrev;
  logic tlrLevel;

  // System-clock domain.
  logic inToggleSys;
  logic inTogglePrev;
  logic tapRunSys;
  logic tapRunPrev;
  logic linked;
  logic pairFull;
  logic [31:0] pairHold;
  logic stagePend;
  logic [31:0] stageWord;
  logic [HDR_CNT_W-1:0] writeLeft;
  logic [HDR_ADDR_W-1:0] writeAddr;
  logic [31:0] readWord;
  logic readToggle;

  always_comb begin
    next_tapState = tapState;
    case (tapState)
      TAP_RESET: next_tapState = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: next_tapState = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: next_tapState = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: next_tapState = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: next_tapState = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: next_tapState = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: next_tapState = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: next_tapState = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: next_tapState = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: next_tapState = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: next_tapState = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: next_tapState = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: next_tapState = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: next_tapState = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: next_tapState = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: next_tapState = tms ? TAP_SEL_DR : TAP_IDLE;
      default: next_tapState = TAP_RESET;
    endcase
  end

  wire selCfgIn = (instr == INSTR_CFG_IN);
  wire selCfgOut = (instr == INSTR_CFG_OUT);
  wire shiftDr = (tapState == TAP_SHIFT_DR);
  wire shiftIr = (tapState == TAP_SHIFT_IR);
  wire inWordDone = shiftDr && selCfgIn && (inCount == LAST_BIT);
  wire readSeen = (readToggleTck != readTogglePrev);
  wire tdoNext = shiftIr ? irShift[0] : selCfgOut ? outShift[31] : selCfgIn ? inShift[31] : bypassBit;

  // Inputs sampled on the rising edge of the test clock.
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      tapState <= TAP_RESET;
    end else begin
      tapState <= next_tapState;
    end
  end

  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      irShift <= '0;
      instr <= INSTR_BYPASS;
    end else if (tapState == TAP_RESET) begin
      instr <= INSTR_BYPASS;
    end else if (tapState == TAP_CAP_IR) begin
      irShift <= IR_CAPTURE;
    end else if (shiftIr) begin
      irShift <= {tdi, irShift[IR_WIDTH-1:1]};
    end else if (tapState == TAP_UPD_IR) begin
      instr <= irShift;
    end
  end

  // Packet words enter MSB first; the word is complete on the 32nd shift, which may be the exit shift.
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      inShift <= '0;
      inCount <= '0;
      inWord <= '0;
      inToggle <= 1'b0;
      bypassBit <= 1'b0;
    end else begin
      bypassBit <= shiftDr ? tdi : 1'b0;
      if (tapState == TAP_CAP_DR) begin
        inCount <= '0;
      end else if (shiftDr && selCfgIn) begin
        inShift <= {inShift[30:0], tdi};
        inCount <= inCount + 5'h01;
      end
      if (inWordDone) begin
        inWord <= {inShift[30:0], tdi};
        inToggle <= ~inToggle;
      end
    end
  end

  // Read data stays stable in the system domain after its toggle flips, so it is taken whole here.
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      readTogglePrev <= 1'b0;
      outHold <= READ_RESET;
      outShift <= '0;
      tlrLevel <= 1'b1;
    end else begin
      readTogglePrev <= readToggleTck;
      tlrLevel <= (next_tapState == TAP_RESET);
      if (readSeen) begin
        outHold <= readWord;
      end
      if (tapState == TAP_CAP_DR && selCfgOut) begin
        outShift <= outHold;
      end else if (shiftDr && selCfgOut) begin
        outShift <= {outShift[30:0], tdi};
      end
    end
  end

  // The output pin changes half a period after the host's sampling edge.
  always_ff @(negedge tck or negedge rst_n) begin
    if (!rst_n) begin
      tdo <= 1'b0;
      tdoOe_n <= 1'b1;
    end else begin
      tdo <= tdoNext;
      tdoOe_n <= !(shiftDr || shiftIr);
    end
  end

  jcr_sync #(.WIDTH(1)) readSync (
    .clock(tck),
    .rst_n(rst_n),
    .d(readToggle),
    .q(readToggleTck)
  );

  // The inverse of the reset level crosses, so the synchroniser's reset value matches the idle level.
  jcr_sync #(.WIDTH(2)) linkSync (
    .clock(clock),
    .rst_n(rst_n),
    .d({!tlrLevel, inToggle}),
    .q({tapRunSys, inToggleSys})
  );

  // Packet processor. Test-port words take priority; the parallel port waits a cycle.
  wire jtagNew = (inToggleSys != inTogglePrev);
  wire parTake = parValid && parReady;
  wire wordIn = jtagNew || parTake;
  wire [31:0] arrWord = jtagNew ? inWord : parWord;
  wire tlrEntry = tapRunPrev && !tapRunSys;
  wire syncHit = wordIn && !linked && (arrWord == SYNC_WORD);
  wire pairDone = wordIn && linked && pairFull;
  wire execValid = pairDone || stagePend;
  wire [31:0] execWord = stagePend ? stageWord : pairHold;
  wire isData = (writeLeft != '0);
  wire [2:0] hdrType = execWord[HDR_TYPE_LSB +: 3];
  wire [1:0] hdrOp = execWord[HDR_OP_LSB +: 2];
  wire [HDR_ADDR_W-1:0] hdrAddr = execWord[HDR_ADDR_LSB +: HDR_ADDR_W];
  wire [HDR_CNT_W-1:0] hdrCnt = execWord[HDR_CNT_W-1:0];
  wire isHdr1 = execValid && !isData && (hdrType == HDR_TYPE1);
  wire doRead = isHdr1 && (hdrOp == OP_READ) && (hdrCnt != '0);
  wire doWrite = isHdr1 && (hdrOp == OP_WRITE);
  wire dataWr = execValid && isData;
  wire wrOption = dataWr && (writeAddr == ADDR_OPTION);
  wire releaseCmd = dataWr && (writeAddr == ADDR_CMD) && (execWord == CMD_RELEASE_LINK);
  wire dropLink = releaseCmd || tlrEntry;
  wire [31:0] readValue = (hdrAddr == ADDR_STAT) ? statusWord :
                          (hdrAddr == ADDR_OPTION) ? optionWord : READ_RESET;

  assign parReady = !stagePend && !jtagNew;
  assign linkActive = linked;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      inTogglePrev <= 1'b0;
      tapRunPrev <= 1'b0;
      linked <= 1'b0;
    end else begin
      inTogglePrev <= inToggleSys;
      tapRunPrev <= tapRunSys;
      if (syncHit) begin
        linked <= 1'b1;
      end else if (dropLink) begin
        linked <= 1'b0;
      end
    end
  end

  // A word is held until its partner arrives; the pair then executes on two consecutive cycles.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pairFull <= 1'b0;
      pairHold <= NOOP_WORD;
      stagePend <= 1'b0;
      stageWord <= NOOP_WORD;
    end else if (dropLink || syncHit) begin
      pairFull <= 1'b0;
      stagePend <= 1'b0;
    end else begin
      stagePend <= pairDone;
      if (pairDone) begin
        stageWord <= arrWord;
        pairFull <= 1'b0;
      end else if (wordIn && linked) begin
        pairHold <= arrWord;
        pairFull <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      writeLeft <= '0;
      writeAddr <= '0;
      optionWord <= OPTION_RESET;
      readWord <= READ_RESET;
      readToggle <= 1'b0;
    end else begin
      if (dropLink) begin
        writeLeft <= '0;
      end else if (doWrite) begin
        writeAddr <= hdrAddr;
        writeLeft <= hdrCnt;
      end else if (dataWr) begin
        writeLeft <= writeLeft - 11'h001;
      end
      if (wrOption) begin
        optionWord <= execWord;
      end
      if (doRead) begin
        readWord <= readValue;
        readToggle <= ~readToggle;
      end
    end
  end
endmodule : jcr_readback

// File: verif/jcr_readback_chk.sv
// Concurrent checks on the test port and the parallel configuration port.
`timescale 1ns/10ps
module jcr_readback_chk
  import jcr_pkg::*;
(
  // Clocks and reset.
  input wire logic clock,
  input wire logic rst_n,
  input wire logic tck,
  // Test port.
  input wire logic tms,
  input wire logic tdo,
  input wire logic tdoOe_n,
  // Parallel port and state.
  input wire logic [31:0] parWord,
  input wire logic parValid,
  input wire logic parReady,
  input wire logic linkActive
);
  logic tdoRise;
  logic oeRise;
  logic take;
  assign take = parValid && parReady;
  // Taken at the rising edge, so any change while the scan clock is high is caught at the fall.
  always_ff @(posedge tck or negedge rst_n) begin
    if (!rst_n) begin
      tdoRise <= 1'b0;
      oeRise <= 1'b1;
    end else begin
      tdoRise <= tdo;
      oeRise <= tdoOe_n;
    end
  end
  AST_TDO_FALL: assert property (@(negedge tck) disable iff (!rst_n) tdo == tdoRise)
    else $error("tdo moved off the falling edge");
  AST_OE_FALL: assert property (@(negedge tck) disable iff (!rst_n) tdoOe_n == oeRise)
    else $error("tdo enable moved off the falling edge");
  AST_TLR_OE: assert property (@(posedge tck) disable iff (!rst_n) tms [*5] |=> tdoOe_n)
    else $error("tdo driven in reset state");
  AST_TLR_LINK: assert property (@(posedge tck) disable iff (!rst_n) tms [*5] |-> ##2 !linkActive)
    else $error("link not released by reset state");
  AST_IR_ENTRY: assert property (@(posedge tck) disable iff (!rst_n)
    tms [*5] ##1 !tms [*2] ##1 tms [*2] ##1 !tms [*2] |=> !tdoOe_n && tdo)
    else $error("instruction shift not entered with capture bit");
  AST_DR_ENTRY: assert property (@(posedge tck) disable iff (!rst_n)
    tms [*5] ##1 !tms [*2] ##1 tms [*2] ##1 !tms [*7] ##1 tms [*3] ##1 !tms [*2] |=> !tdoOe_n)
    else $error("data shift not entered");
  AST_PAR_SYNC: assert property (@(posedge clock) disable iff (!rst_n)
    take && parWord == SYNC_WORD |-> ##[1:2] linkActive)
    else $error("parallel sync word ignored");
  AST_PAR_REL: assert property (@(posedge clock) disable iff (!rst_n)
    take && parWord == CMD_RELEASE_LINK |-> ##[1:3] !linkActive)
    else $error("parallel release command ignored");
  COV_SYNC: cover property (@(posedge clock) disable iff (!rst_n) $rose(linkActive));
  COV_REL: cover property (@(posedge clock) disable iff (!rst_n) $fell(linkActive));
  COV_SHIFT: cover property (@(posedge tck) disable iff (!rst_n) $fell(tdoOe_n));
endmodule : jcr_readback_chk
bind jcr_readback jcr_readback_chk jcr_readback_chk_i (.clock(clock), .rst_n(rst_n), .tck(tck), .tms(tms),
  .tdo(tdo), .tdoOe_n(tdoOe_n), .parWord(parWord), .parValid(parValid), .parReady(parReady),
  .linkActive(linkActive));

// File: verif/jcr_host.sv
// Test-port host model that drives scan clock, mode and data.
`timescale 1ns/10ps
module jcr_host
  import jcr_pkg::*;
(
  // Test port.
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  logic [31:0] lastWord;
  event wordDone;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // The scan clock stands low between calls; tdo is taken just before the rise.
  task automatic clk(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #15 o = tdo;
    tck = 1'b1;
    #15 tck = 1'b0;
  endtask : clk
  task automatic walk(input int n, input logic [7:0] p);
    logic o;
    for (int i = 0; i < n; i++) clk(p[i], ~tdi, o);
  endtask : walk
  task automatic shift(input int n, input logic [159:0] d, input bit lsb, output logic [159:0] g);
    int k;
    logic o;
    g = '0;
    for (int i = 0; i < n; i++) begin
      k = lsb ? i : n - 1 - i;
      clk(i == n - 1, d[k], o);
      g[k] = o;
    end
  endtask : shift
  task automatic tlr();
    walk(7, 8'h1f);
  endtask : tlr
  task automatic ir(input logic [5:0] c, input bit fromDr, output logic [159:0] g);
    if (fromDr) walk(5, 8'h07);
    else walk(4, 8'h03);
    shift(6, 160'(c), 1'b1, g);
  endtask : ir
  task automatic dr(input int n, input logic [159:0] d, output logic [159:0] g);
    walk(4, 8'h03);
    shift(n, d, 1'b0, g);
  endtask : dr
  task automatic readReg(input logic [31:0] hdr);
    logic [159:0] g;
    tlr();
    ir(INSTR_CFG_IN, 1'b0, g);
    dr(160, {SYNC_WORD, hdr, {3{NOOP_WORD}}}, g);
    ir(INSTR_CFG_OUT, 1'b1, g);
    dr(32, 160'h0, g);
    lastWord = g[31:0];
    ->wordDone;
    ir(INSTR_CFG_IN, 1'b1, g);
    dr(128, 160'({32'h30008001, CMD_RELEASE_LINK, {2{NOOP_WORD}}}), g);
    tlr();
  endtask : readReg
endmodule : jcr_host

// File: verif/jcr_readback_tb.sv
// Self-checking bench for the test-port configuration readback block.
`timescale 1ns/10ps
module jcr_readback_tb;
  import jcr_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic tck, tms, tdi, tdo, tdoOe_n, parReady, linkActive;
  logic parValid = 1'b0;
  logic [31:0] parWord = 32'h0;
  logic [31:0] statusWord = 32'h0;
  logic [31:0] optionWord, v, expW;
  logic [159:0] g;
  logic [31:0] expQ[$];
  int n_fail = 0;
  int n_compared = 0;
  always #4 clock = ~clock;
  jcr_readback jcr_readback_i (.clock(clock), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdoOe_n(tdoOe_n), .parWord(parWord), .parValid(parValid), .parReady(parReady),
    .statusWord(statusWord), .optionWord(optionWord), .linkActive(linkActive));
  jcr_host jcr_host_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  // A released parallel bus shows the inverse so a stale word is never mistaken for a new one.
  task automatic par(input logic [31:0] w);
    int t;
    @(negedge clock);
    parValid = 1'b1;
    parWord = w;
    t = 0;
    while (parReady !== 1'b1 && t < 100) begin
      @(negedge clock);
      t++;
    end
    @(negedge clock);
    parValid = 1'b0;
    parWord = ~w;
  endtask : par
  task automatic rd(input logic [31:0] hdr, input logic [31:0] exp);
    expQ.push_back(exp);
    jcr_host_i.readReg(hdr);
  endtask : rd
  always @(jcr_host_i.wordDone) begin
    expW = expQ.pop_front();
    check("readback", jcr_host_i.lastWord, expW);
  end
  initial begin : watchdog
    #400000;
    n_fail++;
    final_report();
  end
  initial begin : main
    v = $urandom(11048);
    repeat (2) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    check("optionWord", optionWord, OPTION_RESET);
    check("linkActive", 32'(linkActive), 32'h0);
    statusWord = $urandom;
    rd(32'h2800e001, statusWord);
    rd(32'h2800a001, 32'h0);
    v = $urandom | 32'h80000000;
    par(SYNC_WORD);
    par(32'h30012001);
    par(v);
    check("parReady", 32'(parReady), 32'h0);
    repeat (4) @(negedge clock);
    check("optionWord", optionWord, v);
    check("linkActive", 32'(linkActive), 32'h1);
    par(32'h30008001);
    par(CMD_RELEASE_LINK);
    repeat (4) @(negedge clock);
    check("linkActive", 32'(linkActive), 32'h0);
    rd(32'h28012001, v);
    v = $urandom | 32'h80000000;
    jcr_host_i.tlr();
    jcr_host_i.ir(INSTR_CFG_IN, 1'b0, g);
    jcr_host_i.dr(160, {SYNC_WORD, 32'h30012001, v, {2{NOOP_WORD}}}, g);
    repeat (8) @(negedge clock);
    check("optionWord", optionWord, v);
    check("linkActive", 32'(linkActive), 32'h1);
    jcr_host_i.tlr();
    repeat (8) @(negedge clock);
    check("linkActive", 32'(linkActive), 32'h0);
    jcr_host_i.ir(INSTR_CFG_IN, 1'b0, g);
    jcr_host_i.dr(64, 160'({32'h30012001, 32'h1}), g);
    repeat (8) @(negedge clock);
    check("optionWord", optionWord, v);
    final_report();
  end
endmodule : jcr_readback_tb
